/* File: bench/hpa_chk.sv */
`timescale 1ns/10ps
module hpa_chk (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_out,
  input wire logic sda_dev_oe_n,
  input wire logic sda_host_out,
  input wire logic sda_host_oe_n
);
  logic       prev_scl;
  logic       prev_sda;
  logic [3:0] rises;
  logic [7:0] hold;
  wire        start_seen = scl && prev_scl && prev_sda && !sda;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // helper logic
  always_ff @(posedge sys_clk) begin
    prev_scl <= scl;
    prev_sda <= sda;
  end
  // saturated at reset so the first edge after reset never trips
  always_ff @(posedge sys_clk) begin
    if (!reset_n) hold <= 8'hff;
    else if (scl != prev_scl) hold <= 8'h00;
    else if (hold != 8'hff) hold <= hold + 8'h01;
  end
  // rises since the last start, saturating past the first byte
  always_ff @(posedge sys_clk) begin
    if (!reset_n || start_seen) rises <= 4'h0;
    else if (scl && !prev_scl && rises != 4'hf) rises <= rises + 4'h1;
  end
  // ==========================================
  // properties
  property p_scl_half; (scl != prev_scl) |-> hold >= 8'h78; endproperty
  a_scl_half: assert property (p_scl_half) else $error("scl half period too short");
  property p_dev_od; !sda_dev_oe_n |-> !sda_dev_out; endproperty
  a_dev_od: assert property (p_dev_od) else $error("device drives sda high");
  property p_host_od; !sda_host_oe_n |-> !sda_host_out; endproperty
  a_host_od: assert property (p_host_od) else $error("host drives sda high");
  property p_dev_steady; scl && prev_scl |-> $stable(sda_dev_oe_n); endproperty
  a_dev_steady: assert property (p_dev_steady) else $error("device sda moved in scl high");
  property p_ack_slot; $rose(scl) && rises == 4'h8 |-> !sda; endproperty
  a_ack_slot: assert property (p_ack_slot) else $error("address not acknowledged");
  property p_addr_quiet; rises < 4'h8 && !start_seen |-> sda_dev_oe_n; endproperty
  a_addr_quiet: assert property (p_addr_quiet) else $error("device drove in address");
  property p_start_hold; start_seen |-> scl [*8] ##[1:300] !scl; endproperty
  a_start_hold: assert property (p_start_hold) else $error("start not held");
  property p_dev_pull; $fell(sda_dev_oe_n) |-> !scl ##[1:300] $rose(scl); endproperty
  a_dev_pull: assert property (p_dev_pull) else $error("device pull not in scl low");
  property p_stop_free; scl && prev_scl && $rose(sda) |-> sda_dev_oe_n [*4]; endproperty
  a_stop_free: assert property (p_stop_free) else $error("device holds sda at stop");
endmodule // hpa_chk

/* File: bench/testbench.sv */
`timescale 1ns/10ps
module testbench;
  localparam int half    = hpa_pkg::scl_half_cycles;
  localparam int bb_half = 8;
  logic        sys_clk;
  logic        reset_n;
  logic        overtemp_flag;
  logic [1:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic [7:0]  rx;
  logic        ack;
  wire  [12:0] outs;
  int          npoll;
  int          err_count;
  int          n_checks;
  // ptr, data, readback, outputs after the write
  logic [36:0] rows [3] = '{{8'h01, 8'hc2, 8'hc2, 13'h0f00},
                            {8'h02, 8'h3f, 8'h3e, 13'h0cf8},
                            {8'h03, 8'hff, 8'h0b, 13'h0cff}};
  hpa_if link();
  hpa_if link_b();
  hpa_device hpa_device_inst (.sys_clk(sys_clk), .reset_n(reset_n), .link(link),
    .overtemp_flag(overtemp_flag), .global_power_down(outs[12]), .left_amp_on(outs[11]),
    .right_amp_on(outs[10]), .left_mute(outs[9]), .right_mute(outs[8]),
    .gain_code(outs[7:3]), .left_output_float(outs[2]), .right_output_float(outs[1]),
    .low_distortion_sel(outs[0]));
  hpa_host #(.global_power_down_wait(50)) hpa_host_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .link(link), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  // second device faces a bench driver that sends a foreign address
  hpa_device hpa_device_inst_b (.sys_clk(sys_clk), .reset_n(reset_n), .link(link_b),
    .overtemp_flag(overtemp_flag), .global_power_down(), .left_amp_on(), .right_amp_on(),
    .left_mute(), .right_mute(), .gain_code(), .left_output_float(),
    .right_output_float(), .low_distortion_sel());
  hpa_chk hpa_chk_inst (.sys_clk(sys_clk), .reset_n(reset_n), .scl(link.scl),
    .sda(link.sda), .sda_dev_out(link.sda_dev_out), .sda_dev_oe_n(link.sda_dev_oe_n),
    .sda_host_out(link.sda_host_out), .sda_host_oe_n(link.sda_host_oe_n));
  // ==========================================
  // tasks
  task automatic check(input string what, input logic [12:0] exp, input logic [12:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic host_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic host_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // bounded poll; a stuck busy stops after 20000 polls and fails the nack busy check
  task automatic wait_idle(output int n);
    logic [7:0] s;
    n = 0;
    s = 8'h01;
    while (s[0] !== 1'b0 && n < 20000) begin
      host_rd(hpa_pkg::host_ctl, s);
      n++;
    end
    check("nack busy", 13'h0000, {11'h000, s[1:0]});
  endtask
  task automatic i2c_write(input logic [7:0] ptr, input logic [7:0] dat);
    host_wr(2'h1, ptr);
    host_wr(2'h2, dat);
    host_wr(hpa_pkg::host_ctl, 8'h01);
    wait_idle(npoll);
  endtask
  task automatic i2c_read(input logic [7:0] ptr, output logic [7:0] d);
    host_wr(2'h1, ptr);
    host_wr(hpa_pkg::host_ctl, 8'h03);
    wait_idle(npoll);
    host_rd(hpa_pkg::host_rdata, d);
  endtask
  task automatic bb_bit(input logic b, output logic s);
    link_b.sda_host_oe_n <= b;
    repeat (bb_half) @(posedge sys_clk);
    link_b.scl <= 1'b1;
    repeat (bb_half) @(posedge sys_clk);
    s = link_b.sda;
    link_b.scl <= 1'b0;
  endtask
  task automatic bb_byte(input logic [7:0] v, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) bb_bit(v[i], s);
    bb_bit(1'b1, a);
  endtask
  // start leaves scl low; stop leaves both high
  task automatic bb_edge(input logic start);
    @(posedge sys_clk);
    link_b.sda_host_oe_n <= start;
    repeat (bb_half) @(posedge sys_clk);
    link_b.scl <= 1'b1;
    repeat (bb_half) @(posedge sys_clk);
    link_b.sda_host_oe_n <= !start;
    repeat (bb_half) @(posedge sys_clk);
    if (start) begin
      link_b.scl <= 1'b0;
      repeat (bb_half) @(posedge sys_clk);
    end
  endtask
  // ==========================================
  // clock, watchdog
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (90000) @(posedge sys_clk);
    err_count++;
    stop_test();
  end
  // ==========================================
  // main sequence
  initial begin
    err_count = 0;
    n_checks = 0;
    reset_n = 1'b0;
    overtemp_flag = 1'b1;
    addr = 2'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    link_b.scl = 1'b1;
    link_b.sda_host_out = 1'b0;
    link_b.sda_host_oe_n = 1'b1;
    repeat (12) @(posedge sys_clk);
    #1 check("reset outputs", 13'h1300, outs);
    @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    for (int i = 0; i < 3; i++) begin
      i2c_write(rows[i][36:29], rows[i][28:21]);
      check("outputs", rows[i][12:0], outs);
      i2c_read(rows[i][36:29], rx);
      check("readback", {5'h00, rows[i][20:13]}, {5'h00, rx});
    end
    i2c_read(hpa_pkg::reg_part_info, rx);
    check("part info", {5'h00, hpa_pkg::part_info_value}, {5'h00, rx});
    // shutdown: busy must outlast the commit by more than two scl half periods plus 25 cycles
    host_wr(2'h1, 8'h01);
    host_wr(2'h2, 8'h01);
    host_wr(hpa_pkg::host_ctl, 8'h01);
    for (npoll = 0; outs[12] !== 1'b1 && npoll < 20000; npoll++) @(posedge sys_clk);
    wait_idle(npoll);
    check("shutdown hold", 13'h0001, {12'h000, 2 * npoll > 2 * half + 25});
    check("shutdown outputs", 13'h10ff, outs);
    bb_edge(1'b1);
    bb_byte(8'hc2, ack);
    check("foreign ack", 13'h0001, {12'h000, ack});
    bb_byte(8'hc0, ack);
    check("ignored ack", 13'h0001, {12'h000, ack});
    bb_edge(1'b0);
    bb_edge(1'b1);
    bb_byte(8'hc0, ack);
    check("own ack", 13'h0000, {12'h000, ack});
    bb_edge(1'b0);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (12) @(posedge sys_clk);
    #1 check("second reset", 13'h1300, outs);
    stop_test();
  end
endmodule // testbench

/* File: common/hpa_if.sv */
`timescale 1ns/10ps
interface hpa_if;
  logic scl;
  logic sda_dev_out;
  logic sda_dev_oe_n;
  logic sda_host_out;
  logic sda_host_oe_n;
  logic sda;
  assign sda = (!sda_dev_oe_n && !sda_dev_out) || (!sda_host_oe_n && !sda_host_out) ? 1'b0 : 1'b1;
  modport device (input scl, input sda, output sda_dev_out, output sda_dev_oe_n);
  modport host (output scl, input sda, output sda_host_out, output sda_host_oe_n);
endinterface

/* File: common/hpa_pkg.sv */
package hpa_pkg;
  // ==========================================
  // link
  localparam logic [6:0] slave_addr       = 7'h60;
  localparam logic [2:0] bit_last         = 3'h7;
  localparam int         sys_clk_mhz      = 100;
  localparam int         scl_min_ns       = 2500;
  localparam int         scl_half_cycles  = (scl_min_ns * sys_clk_mhz + 1999) / 2000;
  localparam int         global_power_down_wait_ms     = 3;
  localparam int         global_power_down_wait_cycles = global_power_down_wait_ms * sys_clk_mhz * 1000;
  // ==========================================
  // register map
  localparam logic [7:0] reg_amp_power    = 8'h01;
  localparam logic [7:0] reg_gain_mute    = 8'h02;
  localparam logic [7:0] reg_output_opt   = 8'h03;
  localparam logic [7:0] reg_part_info    = 8'h04;
  localparam logic [7:0] rst_amp_power    = 8'h01;
  localparam logic [7:0] rst_gain_mute    = 8'hc0;
  localparam logic [7:0] rst_output_opt   = 8'h00;
  localparam logic [7:0] part_info_value  = 8'h5a; // arbitrary identity value
  localparam logic [7:0] mask_amp_power   = 8'hc1;
  localparam logic [7:0] mask_gain_mute   = 8'hfe;
  localparam logic [7:0] mask_output_opt  = 8'h0b;
  localparam int         b_power_down     = 0;
  localparam int         b_overtemp       = 1;
  localparam int         b_right_on       = 6;
  localparam int         b_left_on        = 7;
  localparam int         b_right_mute     = 6;
  localparam int         b_left_mute      = 7;
  localparam int         b_gain_lo        = 1;
  localparam int         b_gain_hi        = 5;
  localparam int         b_right_float    = 0;
  localparam int         b_left_float     = 1;
  localparam int         b_low_dist       = 3;
  // ==========================================
  // host register port
  localparam logic [1:0] host_ctl         = 2'h0;
  localparam logic [1:0] host_status      = 2'h1;
  localparam logic [1:0] host_rdata       = 2'h2;
  localparam int         ctl_go           = 0;
  localparam int         ctl_read         = 1;
endpackage

/* File: src/hpa_device.sv */
`timescale 1ns/10ps
module hpa_device (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  hpa_if.device     link,
  input  wire logic overtemp_flag,
  output logic      global_power_down,
  output logic      left_amp_on,
  output logic      right_amp_on,
  output logic      left_mute,
  output logic      right_mute,
  output logic [4:0] gain_code,
  output logic      left_output_float,
  output logic      right_output_float,
  output logic      low_distortion_sel
);
  typedef enum logic [4:0] {
    st_idle = 5'h01, st_addr = 5'h02, st_ptr = 5'h04, st_wdat = 5'h08, st_rdat = 5'h10
  } hpa_state_t;
  // ==========================================
  // pin sampling, three stages each
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic [2:0] hot_sync;
  logic       scl_s;
  logic       sda_s;
  logic       hot_s;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      hot_sync <= 3'h0;
    end else begin
      scl_sync <= {scl_sync[1:0], link.scl};
      sda_sync <= {sda_sync[1:0], link.sda};
      hot_sync <= {hot_sync[1:0], overtemp_flag};
    end
  end
  // change accepted once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      scl_s <= 1'b1;
      sda_s <= 1'b1;
      hot_s <= 1'b0;
    end else begin
      if (scl_sync[1] == scl_sync[2]) scl_s <= scl_sync[2];
      if (sda_sync[1] == sda_sync[2]) sda_s <= sda_sync[2];
      if (hot_sync[1] == hot_sync[2]) hot_s <= hot_sync[2];
    end
  end
  logic scl_d;
  logic sda_d;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  assign scl_rise   = scl_s && !scl_d;
  assign scl_fall   = !scl_s && scl_d;
  assign start_seen = scl_s && scl_d && sda_d && !sda_s;
  assign stop_seen  = scl_s && scl_d && !sda_d && sda_s;
  // ==========================================
  // byte engine
  hpa_state_t state;
  logic [2:0] bit_cnt;
  logic       ack_slot;
  logic [7:0] shift;
  logic [7:0] pointer;
  logic       rd_mode;
  logic       ack_drive;
  logic       tx_bit;
  logic       wr_pulse;
  logic [7:0] rd_value;
  always_comb begin
    unique case (pointer)
      hpa_pkg::reg_amp_power:
        rd_value = {left_amp_on, right_amp_on, 4'h0, hot_s, global_power_down};
      hpa_pkg::reg_gain_mute:  rd_value = {left_mute, right_mute, gain_code, 1'b0};
      hpa_pkg::reg_output_opt:
        rd_value = {4'h0, low_distortion_sel, 1'b0, left_output_float, right_output_float};
      hpa_pkg::reg_part_info:  rd_value = hpa_pkg::part_info_value;
      default:                 rd_value = 8'h00;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state     <= st_idle;
      bit_cnt   <= 3'h0;
      ack_slot  <= 1'b0;
      shift     <= 8'h00;
      pointer   <= 8'h00;
      rd_mode   <= 1'b0;
      ack_drive <= 1'b0;
      tx_bit    <= 1'b1;
      wr_pulse  <= 1'b0;
    end else begin
      wr_pulse <= 1'b0;
      if (start_seen) begin
        state     <= st_addr;
        bit_cnt   <= 3'h0;
        ack_slot  <= 1'b0;
        ack_drive <= 1'b0;
        tx_bit    <= 1'b1;
      end else if (stop_seen) begin
        state     <= st_idle;
        ack_drive <= 1'b0;
        tx_bit    <= 1'b1;
      end else if (state != st_idle) begin
        // rises shift nothing in while we transmit
        if (scl_rise && !ack_slot && state != st_rdat) begin
          shift   <= {shift[6:0], sda_s};
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == hpa_pkg::bit_last) ack_slot <= 1'b1;
        end else if (scl_rise && ack_slot && state == st_rdat && sda_s) begin
          state <= st_idle; // master nack ends read
        end else if (scl_fall && ack_slot && !ack_drive && bit_cnt == 3'h0 && tx_bit) begin
          // ninth slot opens after eighth fall
          unique case (state)
            st_addr: begin
              if (shift[7:1] == hpa_pkg::slave_addr) begin
                ack_drive <= 1'b1;
                rd_mode   <= shift[0];
              end else begin
                state    <= st_idle;
                ack_slot <= 1'b0;
              end
            end
            st_ptr: begin
              pointer   <= shift;
              ack_drive <= 1'b1;
            end
            st_wdat: begin
              wr_pulse  <= 1'b1;
              ack_drive <= 1'b1;
            end
            st_rdat: tx_bit <= 1'b0;
            default: state <= st_idle;
          endcase
          if (state == st_rdat) ack_drive <= 1'b0;
        end else if (scl_fall && ack_slot && (ack_drive || !tx_bit)) begin
          // ninth clock over
          ack_slot  <= 1'b0;
          ack_drive <= 1'b0;
          tx_bit    <= 1'b1;
          unique case (state)
            st_addr: begin
              state <= rd_mode ? st_rdat : st_ptr;
              if (rd_mode) begin
                shift <= {rd_value[6:0], 1'b0};
                tx_bit <= rd_value[7];
                bit_cnt <= 3'h1;
              end
            end
            st_ptr:  state <= st_wdat;
            st_wdat: state <= st_wdat;
            st_rdat: state <= st_rdat;
            default: state <= st_idle;
          endcase
        end else if (scl_fall && state == st_rdat && !ack_slot) begin
          tx_bit <= shift[7]; // change only while scl low
          shift  <= {shift[6:0], 1'b0};
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h0) begin
            ack_slot <= 1'b1;
            tx_bit   <= 1'b1;
          end
        end
      end
    end
  end
  // open drain: only ever pull low, scl is never driven
  assign link.sda_dev_out  = 1'b0;
  assign link.sda_dev_oe_n = !(ack_drive || (state == st_rdat && !tx_bit));
  // ==========================================
  // control registers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      global_power_down  <= hpa_pkg::rst_amp_power[hpa_pkg::b_power_down];
      left_amp_on        <= hpa_pkg::rst_amp_power[hpa_pkg::b_left_on];
      right_amp_on       <= hpa_pkg::rst_amp_power[hpa_pkg::b_right_on];
      left_mute          <= hpa_pkg::rst_gain_mute[hpa_pkg::b_left_mute];
      right_mute         <= hpa_pkg::rst_gain_mute[hpa_pkg::b_right_mute];
      gain_code          <= hpa_pkg::rst_gain_mute[hpa_pkg::b_gain_hi:hpa_pkg::b_gain_lo];
      left_output_float  <= hpa_pkg::rst_output_opt[hpa_pkg::b_left_float];
      right_output_float <= hpa_pkg::rst_output_opt[hpa_pkg::b_right_float];
      low_distortion_sel <= hpa_pkg::rst_output_opt[hpa_pkg::b_low_dist];
    end else if (wr_pulse) begin
      if (pointer == hpa_pkg::reg_amp_power) begin
        global_power_down <= shift[hpa_pkg::b_power_down];
        left_amp_on       <= shift[hpa_pkg::b_left_on];
        right_amp_on      <= shift[hpa_pkg::b_right_on];
      end
      if (pointer == hpa_pkg::reg_gain_mute) begin
        left_mute  <= shift[hpa_pkg::b_left_mute];
        right_mute <= shift[hpa_pkg::b_right_mute];
        gain_code  <= shift[hpa_pkg::b_gain_hi:hpa_pkg::b_gain_lo];
      end
      if (pointer == hpa_pkg::reg_output_opt) begin
        left_output_float  <= shift[hpa_pkg::b_left_float];
        right_output_float <= shift[hpa_pkg::b_right_float];
        low_distortion_sel <= shift[hpa_pkg::b_low_dist];
      end
    end
  end
endmodule // hpa_device

/* File: src/hpa_host.sv */
`timescale 1ns/10ps
module hpa_host #(
  parameter int global_power_down_wait = hpa_pkg::global_power_down_wait_cycles
) (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  hpa_if.host             link,
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata
);
  typedef enum logic [6:0] {
    hs_idle = 7'h01, hs_start = 7'h02, hs_bit = 7'h04, hs_ack = 7'h08,
    hs_stop = 7'h10, hs_rstart = 7'h20, hs_wait = 7'h40
  } hpa_host_state_t;
  // ==========================================
  // command registers
  logic [7:0] ptr_reg;
  logic [7:0] data_reg;
  logic       rd_req;
  logic       go;
  logic       busy;
  logic       nack_err;
  logic [7:0] rx_byte;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ptr_reg  <= 8'h00;
      data_reg <= 8'h00;
      rd_req   <= 1'b0;
      go       <= 1'b0;
    end else begin
      go <= 1'b0;
      if (wr && addr == hpa_pkg::host_ctl && !busy) begin
        go     <= wdata[hpa_pkg::ctl_go];
        rd_req <= wdata[hpa_pkg::ctl_read];
      end
      if (wr && addr == hpa_pkg::host_status) ptr_reg  <= wdata;
      if (wr && addr == hpa_pkg::host_rdata)  data_reg <= wdata;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!reset_n) rdata <= 8'h00;
    else if (rd) begin
      unique case (addr)
        hpa_pkg::host_ctl:    rdata <= {6'h00, nack_err, busy};
        hpa_pkg::host_status: rdata <= ptr_reg;
        hpa_pkg::host_rdata:  rdata <= rx_byte;
        default:              rdata <= data_reg;
      endcase
    end
  end
  // ==========================================
  // bit engine, divider makes scl
  hpa_host_state_t st;
  logic [15:0] div;
  logic        phase;
  logic [1:0]  byte_no;
  logic [2:0]  bcnt;
  logic [7:0]  tx;
  logic        second_addr;
  logic [31:0] wait_cnt;
  logic        sda_o;
  logic        scl_o;
  logic        tick;
  assign tick = (div == 16'(hpa_pkg::scl_half_cycles - 1));
  assign busy = (st != hs_idle);
  always_ff @(posedge sys_clk) begin
    if (!reset_n) div <= 16'h0000;
    else div <= (tick || st == hs_idle) ? 16'h0000 : div + 16'h0001;
  end
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st <= hs_idle; phase <= 1'b0; byte_no <= 2'h0; bcnt <= 3'h0; tx <= 8'h00;
      second_addr <= 1'b0; wait_cnt <= 32'h0; sda_o <= 1'b1; scl_o <= 1'b1;
      nack_err <= 1'b0; rx_byte <= 8'h00;
    end else begin
      unique case (st)
        hs_idle: if (go) begin
          st <= hs_start; phase <= 1'b0; byte_no <= 2'h0; second_addr <= 1'b0;
          nack_err <= 1'b0; tx <= {hpa_pkg::slave_addr, 1'b0};
        end
        hs_start, hs_rstart: if (tick) begin
          // restart: release sda with scl low, then raise scl, then drop sda
          if (!phase) begin
            sda_o <= 1'b1; scl_o <= (st == hs_start); phase <= 1'b1;
          end else if (!scl_o) begin
            scl_o <= 1'b1;
          end else begin
            sda_o <= 1'b0; st <= hs_bit; bcnt <= 3'h0; phase <= 1'b0;
          end
        end
        hs_bit: if (tick) begin
          if (!phase) begin
            scl_o <= 1'b0; phase <= 1'b1;
            sda_o <= (byte_no == 2'h3) ? 1'b1 : tx[7]; // change with scl low
          end else begin
            scl_o <= 1'b1; phase <= 1'b0;
            tx <= {tx[6:0], 1'b0};
            if (byte_no == 2'h3) rx_byte <= {rx_byte[6:0], link.sda};
            bcnt <= bcnt + 3'h1;
            if (bcnt == hpa_pkg::bit_last) st <= hs_ack;
          end
        end
        hs_ack: if (tick) begin
          if (!phase) begin
            scl_o <= 1'b0; phase <= 1'b1;
            sda_o <= 1'b1; // release; read ends in nack
          end else begin
            scl_o <= 1'b1; phase <= 1'b0; bcnt <= 3'h0;
            if (byte_no != 2'h3 && link.sda) begin
              nack_err <= 1'b1; st <= hs_stop;
            end else if (byte_no == 2'h0) begin
              byte_no <= second_addr ? 2'h3 : 2'h1; tx <= ptr_reg; st <= hs_bit;
            end else if (byte_no == 2'h1 && rd_req) begin
              st <= hs_rstart; second_addr <= 1'b1; byte_no <= 2'h0;
              tx <= {hpa_pkg::slave_addr, 1'b1};
            end else if (byte_no == 2'h1) begin
              byte_no <= 2'h2; tx <= data_reg; st <= hs_bit;
            end else st <= hs_stop;
          end
        end
        hs_stop: if (tick) begin
          if (!phase) begin
            scl_o <= 1'b0; sda_o <= 1'b0; phase <= 1'b1;
          end else if (!scl_o) scl_o <= 1'b1;
          else begin
            sda_o <= 1'b1; phase <= 1'b0; wait_cnt <= 32'h0;
            st <= (byte_no == 2'h2 && ptr_reg == hpa_pkg::reg_amp_power
                   && data_reg[hpa_pkg::b_power_down]) ? hs_wait : hs_idle;
          end
        end
        hs_wait: begin
          wait_cnt <= wait_cnt + 32'h1;
          if (wait_cnt == 32'(global_power_down_wait - 1)) st <= hs_idle;
        end
        default: st <= hs_idle;
      endcase
    end
  end
  assign link.scl           = scl_o;
  assign link.sda_host_out  = 1'b0;
  assign link.sda_host_oe_n = sda_o;
endmodule // hpa_host
